// >>> dew_pkg.sv
// Shared constants, types and register map for the data EEPROM guard
package dew_pkg;

    // --------------------
    // Timing
    // --------------------
    localparam int CLK_MHZ = 200;              // Clock rate in MHz
    localparam int WRITE_TIME_US = 4;          // Self-timed byte write, us
    localparam int PWRT_TIME_US = 64000;       // Power-up timer period, us
    localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
    localparam int PWRT_CYCLES = PWRT_TIME_US * CLK_MHZ;
    localparam int TIMER_W = 24;               // Width of both down counters

    // --------------------
    // Register map (byte addresses)
    // --------------------
    localparam logic [7:0] OFS_ADDR = 8'h00;   // nvm_byte_address
    localparam logic [7:0] OFS_DATA = 8'h04;   // nvm_byte_data
    localparam logic [7:0] OFS_KEY = 8'h08;    // unlock_key_port
    localparam logic [7:0] OFS_CTRL = 8'h0c;   // nvm_access_control
    localparam logic [7:0] OFS_STATUS = 8'h10; // Done flag status

    // Control field positions
    localparam int CTL_PGM = 7;                // program_space_select
    localparam int CTL_CFG = 6;                // config_space_select
    localparam int CTL_FREE = 4;               // Row erase enable
    localparam int CTL_ABORT = 3;              // write_abort_flag
    localparam int CTL_WRITE_ENABLE_LATCH = 2;               // write_enable_latch
    localparam int CTL_WR = 1;                 // Write start
    localparam int CTL_RD = 0;                 // Read start
    localparam int STS_DONE = 0;               // nvm_done_flag

    // Values after reset
    localparam logic [7:0] ADDR_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;

    // Unlock keys
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;

    // --------------------
    // Types
    // --------------------
    typedef enum logic [1:0] {
        DEW_KEY_IDLE = 2'b00,
        DEW_KEY_FIRST = 2'b01,
        DEW_KEY_ARMED = 2'b10
    } dew_key_state_t;

    typedef enum logic {
        DEW_WR_IDLE = 1'b0,
        DEW_WR_BUSY = 1'b1
    } dew_wr_state_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } dew_apb_req_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
        logic [7:0] data;
    } dew_ext_req_t;

    typedef struct packed {
        logic en;
        logic [7:0] addr;
        logic [7:0] data;
    } dew_mem_wr_t;

endpackage

// >>> dew_byte_array.sv
// Byte-wide storage array with one write and two read ports
`timescale 1ns/1ps
`default_nettype none
module dew_byte_array (
    input wire logic clk_sys_in,                  // System clock
    input wire dew_pkg::dew_mem_wr_t wr_in,       // Write request
    input wire logic [7:0] rd_a_addr_in,          // CPU read address
    input wire logic [7:0] rd_b_addr_in,          // External read address
    output logic [7:0] rd_a_data_out,             // CPU read byte
    output logic [7:0] rd_b_data_out              // External read byte
);
    // --------------------
    // Storage
    // --------------------
    logic [7:0] mem [256];                        // One byte per address

    // Contents have no reset, as a real array keeps its data
    always_ff @(posedge clk_sys_in) begin
        if (wr_in.en) begin
            mem[wr_in.addr] <= wr_in.data;
        end
    end

    // Read ports are combinational
    assign rd_a_data_out = mem[rd_a_addr_in];
    assign rd_b_data_out = mem[rd_b_addr_in];
endmodule
`default_nettype wire

// >>> dew_unlock_seq.sv
// Two-key unlock sequence tracker
`timescale 1ns/1ps
`default_nettype none
module dew_unlock_seq (
    input wire logic clk_sys_in,                  // System clock
    input wire logic rst_in,                      // Async reset, high
    input wire logic access_in,                   // A bus access completes
    input wire logic key_write_in,                // It writes the key port
    input wire logic [7:0] key_data_in,           // Byte written
    output logic armed_out                        // Both keys seen in order
);
    // --------------------
    // Sequence state
    // --------------------
    dew_pkg::dew_key_state_t state_reg;           // Current step
    dew_pkg::dew_key_state_t state_next;          // Next step

    // Any access other than the expected key restarts the sequence
    always_comb begin
        state_next = state_reg;
        if (access_in) begin
            state_next = dew_pkg::DEW_KEY_IDLE;
            if (key_write_in && key_data_in == dew_pkg::KEY_FIRST) begin
                state_next = dew_pkg::DEW_KEY_FIRST;
            end else if (key_write_in &&
                         key_data_in == dew_pkg::KEY_SECOND &&
                         state_reg == dew_pkg::DEW_KEY_FIRST) begin
                state_next = dew_pkg::DEW_KEY_ARMED;
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= dew_pkg::DEW_KEY_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign armed_out = (state_reg == dew_pkg::DEW_KEY_ARMED);
endmodule
`default_nettype wire

// >>> dew_guard.sv
// Data EEPROM access and write protection, APB register front end
// What this block does
// - Refuse external access while code-protect is set
// - CPU access ignores the code-protect bit
// - Reset clears the write enable latch
// - Block writes during the power-up timer
// - Keys 55h then AAh, then write start
// - Write needs enable latch and unlock both
// - Write start reads set until done
// - Read start loads data from address
// - Byte array with eight-bit address
// - Write end clears start, sets done flag
// - Address, data and control ignore writes while write runs
// - Reset mid-write keeps abort flag, selects
// - Key port reads zero; starts set-only
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module dew_guard #(
    parameter int unsigned WRITE_CYCLES_P = dew_pkg::WRITE_CYCLES,
    parameter int unsigned PWRT_CYCLES_P = dew_pkg::PWRT_CYCLES
) (
    input wire logic clk_sys_in,                  // System clock, 200 MHz
    input wire logic rst_in,                      // Async reset, high
    input wire logic por_in,                      // Power-on indicator
    input wire logic data_protect_in,             // Code-protect config bit
    input wire dew_pkg::dew_apb_req_t apb_in,     // APB request
    output logic [31:0] prdata_out,               // APB read data
    output logic pready_out,                      // APB ready
    output logic pslverr_out,                     // APB error
    input wire dew_pkg::dew_ext_req_t ext_in,     // External programmer
    output logic [7:0] ext_rdata_out,             // External read byte
    output logic ext_ack_out,                     // External access done
    output logic ext_refused_out,                 // External access refused
    output logic write_busy_out,                  // Self-timed write runs
    output logic nvm_done_flag_out                // Write complete flag
);
    // --------------------
    // Declarations
    // --------------------
    logic [7:0] addr_reg;                         // nvm_byte_address
    logic [7:0] data_reg;                         // nvm_byte_data
    logic write_enable_latch_reg;                               // write_enable_latch
    logic free_reg;                               // Row erase enable
    logic pgm_sel_reg;                            // program_space_select
    logic cfg_sel_reg;                            // config_space_select
    logic abort_reg;                              // write_abort_flag
    logic rd_reg;                                 // Read start, one cycle
    logic done_reg;                               // nvm_done_flag
    dew_pkg::dew_wr_state_t wr_state_reg;         // Write sequencer
    logic [dew_pkg::TIMER_W-1:0] wr_cnt_reg;      // Write time left
    logic [dew_pkg::TIMER_W-1:0] pwrt_cnt_reg;    // Power-up time left
    logic pwrt_done_reg;                          // Power-up timer expired
    logic pready_reg;                             // Ready register
    logic pslverr_reg;                            // Error register
    logic [31:0] prdata_reg;                      // Read data register
    logic [7:0] ext_rdata_reg;                    // External read byte
    logic ext_ack_reg;                            // External ack pulse
    logic ext_refused_reg;                        // External refuse pulse
    logic access;                                 // APB access completes
    logic wr_access;                              // Completing write
    logic busy;                                   // Write in progress
    logic ctrl_wr;                                // Accepted control write
    logic wr_req;                                 // Software asks write
    logic wr_start;                               // Write really starts
    logic wr_finish;                              // Last write cycle
    logic rd_go;                                  // Read start accepted
    logic armed;                                  // Keys seen in order
    logic ext_ok;                                 // External access allowed
    logic mapped;                                 // Address decodes
    logic [7:0] ctrl_view;                        // Control as read
    logic [31:0] rd_mux;                          // Read data selection
    logic [7:0] cpu_rbyte;                        // Array byte for CPU
    logic [7:0] ext_rbyte;                        // Array byte for outside
    dew_pkg::dew_mem_wr_t mem_wr;                 // Array write request

    // --------------------
    // Bus decode
    // --------------------
    // Effects land on the edge where the master samples ready high
    assign access = apb_in.psel && apb_in.penable && pready_reg;
    assign wr_access = access && apb_in.pwrite;
    assign busy = (wr_state_reg == dew_pkg::DEW_WR_BUSY);
    assign mapped = (apb_in.paddr == dew_pkg::OFS_ADDR) ||
                    (apb_in.paddr == dew_pkg::OFS_DATA) ||
                    (apb_in.paddr == dew_pkg::OFS_KEY) ||
                    (apb_in.paddr == dew_pkg::OFS_CTRL) ||
                    (apb_in.paddr == dew_pkg::OFS_STATUS);

    // Control writes are dropped while a write runs
    assign ctrl_wr = wr_access && !busy &&
                     apb_in.paddr == dew_pkg::OFS_CTRL;
    assign wr_req = ctrl_wr && apb_in.pwdata[dew_pkg::CTL_WR];
    // Latch must already be set, keys seen, power-up timer over,
    // and the data space selected
    assign wr_start = wr_req && write_enable_latch_reg && armed &&
                      pwrt_done_reg &&
                      !apb_in.pwdata[dew_pkg::CTL_PGM] &&
                      !apb_in.pwdata[dew_pkg::CTL_CFG];
    // Read start is refused for program or config space
    assign rd_go = ctrl_wr && apb_in.pwdata[dew_pkg::CTL_RD] &&
                   !apb_in.pwdata[dew_pkg::CTL_PGM] &&
                   !apb_in.pwdata[dew_pkg::CTL_CFG];
    assign wr_finish = busy && wr_cnt_reg == dew_pkg::TIMER_W'(1);

    // Control as software sees it; bit 5 reads zero
    assign ctrl_view = {pgm_sel_reg, cfg_sel_reg, 1'b0, free_reg,
                        abort_reg, write_enable_latch_reg, busy, rd_reg};

    // --------------------
    // Submodules
    // --------------------
    // Unlock tracker sees every completed access
    dew_unlock_seq u_unlock (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .access_in(access),
        .key_write_in(apb_in.pwrite &&
                      apb_in.paddr == dew_pkg::OFS_KEY),
        .key_data_in(apb_in.pwdata[7:0]),
        .armed_out(armed)
    );

    // One byte per location, eight-bit address
    dew_byte_array u_array (
        .clk_sys_in(clk_sys_in),
        .wr_in(mem_wr),
        .rd_a_addr_in(addr_reg),
        .rd_b_addr_in(ext_in.addr),
        .rd_a_data_out(cpu_rbyte),
        .rd_b_data_out(ext_rbyte)
    );

    // --------------------
    // Array write selection
    // --------------------
    // CPU byte lands at the end of its timed write; external writes
    // only happen while idle, so the two never meet
    always_comb begin
        mem_wr = '0;
        if (wr_finish) begin
            mem_wr.en = 1'b1;
            mem_wr.addr = addr_reg;
            mem_wr.data = data_reg;
        end else if (ext_ok && ext_in.write) begin
            mem_wr.en = 1'b1;
            mem_wr.addr = ext_in.addr;
            mem_wr.data = ext_in.data;
        end
    end

    // --------------------
    // APB answer
    // --------------------
    // Read data selection
    always_comb begin
        rd_mux = '0;
        unique case (apb_in.paddr)
            dew_pkg::OFS_ADDR: rd_mux[7:0] = addr_reg;
            dew_pkg::OFS_DATA: rd_mux[7:0] = data_reg;
            dew_pkg::OFS_CTRL: rd_mux[7:0] = ctrl_view;
            dew_pkg::OFS_STATUS: rd_mux[dew_pkg::STS_DONE] = done_reg;
            default: rd_mux = '0;
        endcase
    end

    // One wait state: ready rises in the second access cycle
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= '0;
        end else if (apb_in.psel && apb_in.penable && !pready_reg) begin
            pready_reg <= 1'b1;
            pslverr_reg <= !mapped;
            prdata_reg <= apb_in.pwrite ? 32'h0000_0000 : rd_mux;
        end else begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= '0;
        end
    end

    // --------------------
    // Address and data registers
    // --------------------
    // Address is frozen while a write runs
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            addr_reg <= dew_pkg::ADDR_RST;
        end else if (wr_access && !busy &&
                     apb_in.paddr == dew_pkg::OFS_ADDR) begin
            addr_reg <= apb_in.pwdata[7:0];
        end
    end

    // Data takes software writes or a read from the array
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            data_reg <= dew_pkg::DATA_RST;
        end else if (rd_go) begin
            data_reg <= cpu_rbyte;
        end else if (wr_access && !busy &&
                     apb_in.paddr == dew_pkg::OFS_DATA) begin
            data_reg <= apb_in.pwdata[7:0];
        end
    end

    // --------------------
    // Control bits with reset
    // --------------------
    // Write enable latch, erase enable and read start
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            write_enable_latch_reg <= 1'b0;
            free_reg <= 1'b0;
            rd_reg <= 1'b0;
        end else begin
            rd_reg <= rd_go;
            if (ctrl_wr) begin
                write_enable_latch_reg <= apb_in.pwdata[dew_pkg::CTL_WRITE_ENABLE_LATCH];
                free_reg <= apb_in.pwdata[dew_pkg::CTL_FREE];
            end
        end
    end

    // --------------------
    // Bits that survive a reset
    // --------------------
    // Abort flag and space selects are cleared by power-on, not by rst_in, so a
    // reset during a timed write leaves the evidence behind
    always_ff @(posedge clk_sys_in) begin
        if (por_in) begin
            abort_reg <= 1'b0;
            pgm_sel_reg <= 1'b0;
            cfg_sel_reg <= 1'b0;
        end else begin
            if (ctrl_wr) begin
                pgm_sel_reg <= apb_in.pwdata[dew_pkg::CTL_PGM];
                cfg_sel_reg <= apb_in.pwdata[dew_pkg::CTL_CFG];
            end
            if (wr_req) begin
                abort_reg <= 1'b1;
            end else if (wr_finish) begin
                abort_reg <= 1'b0;
            end else if (ctrl_wr) begin
                abort_reg <= apb_in.pwdata[dew_pkg::CTL_ABORT];
            end
        end
    end

    // --------------------
    // Write sequencer
    // --------------------
    // Idle until a guarded start, busy for the write time
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            wr_state_reg <= dew_pkg::DEW_WR_IDLE;
            wr_cnt_reg <= '0;
        end else begin
            unique case (wr_state_reg)
                dew_pkg::DEW_WR_IDLE: begin
                    if (wr_start) begin
                        wr_state_reg <= dew_pkg::DEW_WR_BUSY;
                        wr_cnt_reg <= WRITE_CYCLES_P[dew_pkg::TIMER_W-1:0];
                    end
                end
                dew_pkg::DEW_WR_BUSY: begin
                    wr_cnt_reg <= wr_cnt_reg - dew_pkg::TIMER_W'(1);
                    if (wr_finish) begin
                        wr_state_reg <= dew_pkg::DEW_WR_IDLE;
                    end
                end
            endcase
        end
    end

    // Done flag: hardware set beats a software clear in the same cycle
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            done_reg <= 1'b0;
        end else if (wr_finish) begin
            done_reg <= 1'b1;
        end else if (wr_access && apb_in.paddr == dew_pkg::OFS_STATUS &&
                     apb_in.pwdata[dew_pkg::STS_DONE]) begin
            done_reg <= 1'b0;
        end
    end

    // --------------------
    // Power-up timer
    // --------------------
    // Counts down once after reset release; writes wait for it
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            pwrt_cnt_reg <= PWRT_CYCLES_P[dew_pkg::TIMER_W-1:0];
            pwrt_done_reg <= 1'b0;
        end else if (!pwrt_done_reg) begin
            pwrt_cnt_reg <= pwrt_cnt_reg - dew_pkg::TIMER_W'(1);
            if (pwrt_cnt_reg <= dew_pkg::TIMER_W'(1)) begin
                pwrt_done_reg <= 1'b1;
            end
        end
    end

    // --------------------
    // External programming port
    // --------------------
    // Protect bit only gates this port, never the CPU path; writes
    // also wait out the power-up timer; reads and writes both wait out any running CPU write
    assign ext_ok = ext_in.valid && !data_protect_in && !busy &&
                    (!ext_in.write || pwrt_done_reg);

    // One-cycle answer pulses
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            ext_ack_reg <= 1'b0;
            ext_refused_reg <= 1'b0;
            ext_rdata_reg <= '0;
        end else begin
            ext_ack_reg <= ext_ok;
            ext_refused_reg <= ext_in.valid && !ext_ok;
            if (ext_ok && !ext_in.write) begin
                ext_rdata_reg <= ext_rbyte;
            end
        end
    end

    // --------------------
    // Outputs
    // --------------------
    // CPU path reads and writes regardless of protect
    assign prdata_out = prdata_reg;
    assign pready_out = pready_reg;
    assign pslverr_out = pslverr_reg;
    assign ext_rdata_out = ext_rdata_reg;
    assign ext_ack_out = ext_ack_reg;
    assign ext_refused_out = ext_refused_reg;
    assign write_busy_out = wr_state_reg;
    assign nvm_done_flag_out = done_reg;
endmodule
`default_nettype wire

// >>> dew_checker.sv
// Port-level assertions for the data EEPROM guard
`timescale 1ns/1ps
`default_nettype none
module dew_checker #(
    parameter int unsigned WRITE_CYCLES_P = 8
) (
    input wire logic clk_sys_in,              // Clock
    input wire logic rst_in,                  // Reset
    input wire logic data_protect_in,         // Protect bit
    input wire dew_pkg::dew_apb_req_t apb_in, // APB request
    input wire logic [31:0] prdata_out,       // Read data
    input wire logic pready_out,              // Ready
    input wire dew_pkg::dew_ext_req_t ext_in, // External request
    input wire logic ext_refused_out,         // Refused
    input wire logic write_busy_out,          // Busy
    input wire logic nvm_done_flag_out        // Done flag
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    logic acc;           // APB transfer completes
    int unsigned busy_n; // Length of current busy stretch
    assign acc = apb_in.psel & apb_in.penable & pready_out;
    // Count busy cycles so the write time can be checked
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            busy_n <= 0;
        end else begin
            busy_n <= write_busy_out ? busy_n + 1 : 0;
        end
    end
    property p_protect; ext_in.valid && data_protect_in |=> ext_refused_out;
    endproperty
    a_protect: assert property (p_protect) else $error("ext not refused");
    property p_busy_len; $fell(write_busy_out) |-> busy_n == WRITE_CYCLES_P;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("bad write time");
    property p_done; $fell(write_busy_out) |-> nvm_done_flag_out;
    endproperty
    a_done: assert property (p_done) else $error("done flag not set");
    property p_start; $rose(write_busy_out) |-> $past(acc && apb_in.pwrite
        && apb_in.paddr == dew_pkg::OFS_CTRL && apb_in.pwdata[1]); endproperty
    a_start: assert property (p_start) else $error("write without start");
    property p_key_zero; acc && !apb_in.pwrite
        && apb_in.paddr == dew_pkg::OFS_KEY |-> prdata_out == 32'h0; endproperty
    a_key_zero: assert property (p_key_zero) else $error("key read not 0");
    property p_busy_ref; ext_in.valid && write_busy_out |=> ext_refused_out;
    endproperty
    a_busy_ref: assert property (p_busy_ref) else $error("ext during write");
    property p_done_hold; nvm_done_flag_out && !(acc && apb_in.pwrite
        && apb_in.paddr == dew_pkg::OFS_STATUS) |=> nvm_done_flag_out; endproperty
    a_done_hold: assert property (p_done_hold) else $error("done lost");
    property p_upper; pready_out |-> prdata_out[31:8] == 24'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper bits set");
endmodule
bind dew_guard dew_checker #(.WRITE_CYCLES_P(WRITE_CYCLES_P)) i_chk (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .apb_in(apb_in),
    .data_protect_in(data_protect_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .ext_in(ext_in), .write_busy_out(write_busy_out),
    .ext_refused_out(ext_refused_out), .nvm_done_flag_out(nvm_done_flag_out));
`default_nettype wire

// >>> dew_cpu_model.sv
// CPU-side APB master driving the guard's registers
`timescale 1ns/1ps
`default_nettype none
module dew_cpu_model (
    input wire logic clk_sys_in,              // Clock
    input wire logic pready_in,               // Slave ready
    input wire logic [31:0] prdata_in,        // Read data
    output var dew_pkg::dew_apb_req_t apb_out // Request
);
    initial apb_out = '0;
    // One transfer; released address and data show the inverse
    task automatic xfer(input logic wr, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_sys_in);
        apb_out <= '{1'b1, 1'b0, wr, a, d};
        @(posedge clk_sys_in);
        apb_out.penable <= 1'b1;
        do begin
            @(posedge clk_sys_in);
            n++;
        end while (pready_in !== 1'b1 && n < 64);
        q = prdata_in;
        apb_out <= '{1'b0, 1'b0, wr, ~a, ~d};
    endtask
endmodule
`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the data EEPROM guard
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic por_in = 1'b1;
    logic prot = 1'b0;
    dew_pkg::dew_apb_req_t apb;
    dew_pkg::dew_ext_req_t ext = '0;
    logic [31:0] prdata, q;
    logic pready, err, ack, refd, busy, done;
    logic [7:0] erd, a, d;
    logic [31:0] exp_q[$]; // Expected APB read data
    logic [9:0] ext_q[$];  // Expected {ack, refused, data}
    int n_fail = 0;
    int check_count = 0;
    int seed = 32'he1a3;
    always #2.5 clk_sys_in = ~clk_sys_in;
    dew_cpu_model i_cpu (.clk_sys_in(clk_sys_in), .pready_in(pready),
        .prdata_in(prdata), .apb_out(apb));
    dew_guard #(.WRITE_CYCLES_P(16), .PWRT_CYCLES_P(48)) i_dut (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .por_in(por_in),
        .data_protect_in(prot), .apb_in(apb), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(err), .ext_in(ext),
        .ext_rdata_out(erd), .ext_ack_out(ack), .ext_refused_out(refd),
        .write_busy_out(busy), .nvm_done_flag_out(done));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic rd(input logic [7:0] ad, input logic [31:0] e);
        exp_q.push_back(e);
        i_cpu.xfer(1'b0, ad, 32'h0, q);
    endtask
    task automatic wr(input logic [7:0] ad, input logic [7:0] v);
        i_cpu.xfer(1'b1, ad, {24'h0, v}, q);
    endtask
    task automatic ext_go(input logic w, input logic [7:0] ad, v,
            input logic [9:0] e);
        ext_q.push_back(e);
        ext <= '{1'b1, w, ad, v};
        @(posedge clk_sys_in);
        ext <= '{1'b0, ~w, ~ad, ~v};
    endtask
    // Keys, optional read, write start
    task automatic start(input bit mid);
        wr(dew_pkg::OFS_KEY, dew_pkg::KEY_FIRST);
        wr(dew_pkg::OFS_KEY, dew_pkg::KEY_SECOND);
        if (mid) rd(dew_pkg::OFS_ADDR, {24'h0, a});
        wr(dew_pkg::OFS_CTRL, 8'h06);
    endtask
    // Oldest note against each result
    always @(posedge clk_sys_in) begin
        if (pready && !apb.pwrite) check(prdata, exp_q.pop_front());
        if (pready) check(32'(err),
            32'(apb.paddr > dew_pkg::OFS_STATUS));
        if (ack || refd) check({ack, refd, ack ? erd : 8'h00}, ext_q.pop_front());
    end
    initial begin
        repeat (5000) @(posedge clk_sys_in);
        n_fail++;
        complete_run;
    end
    initial begin
        repeat (4) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        por_in <= 1'b0;
        a = 8'h11;
        rd(dew_pkg::OFS_CTRL, 32'h0);
        wr(dew_pkg::OFS_ADDR, a);
        wr(dew_pkg::OFS_CTRL, 8'h04);
        start(0);
        rd(dew_pkg::OFS_CTRL, 32'h0c);
        repeat (30) @(posedge clk_sys_in);
        prot <= 1'b1;
        a = 8'($random(seed));
        d = 8'($random(seed));
        wr(dew_pkg::OFS_ADDR, a);
        wr(dew_pkg::OFS_DATA, d);
        start(0);
        rd(dew_pkg::OFS_CTRL, 32'h0e);
        ext_go(1'b0, a, 8'h00, 10'h100);
        wr(dew_pkg::OFS_ADDR, ~a);
        for (int i = 0; i < 64 && busy !== 1'b0; i++) @(posedge clk_sys_in);
        rd(dew_pkg::OFS_STATUS, 32'h1);
        rd(dew_pkg::OFS_CTRL, 32'h04);
        rd(dew_pkg::OFS_ADDR, {24'h0, a});
        wr(dew_pkg::OFS_DATA, 8'h00);
        wr(dew_pkg::OFS_CTRL, 8'h05);
        rd(dew_pkg::OFS_DATA, {24'h0, d});
        prot <= 1'b0;
        ext_go(1'b0, a, 8'h00, {2'b10, d});
        wr(dew_pkg::OFS_STATUS, 8'h01);
        ext_go(1'b1, a, ~d, {2'b10, d});
        rd(dew_pkg::OFS_STATUS, 32'h0);
        ext_go(1'b0, a, 8'h00, {2'b10, ~d});
        rd(dew_pkg::OFS_KEY, 32'h0);
        rd(8'h14, 32'h0);
        start(1);
        rd(dew_pkg::OFS_CTRL, 32'h0c);
        wr(dew_pkg::OFS_CTRL, 8'h00);
        start(0);
        rd(dew_pkg::OFS_CTRL, 32'h0c);
        start(0);
        repeat (3) @(posedge clk_sys_in);
        rst_in <= 1'b1;
        @(posedge clk_sys_in);
        rst_in <= 1'b0;
        rd(dew_pkg::OFS_CTRL, 32'h08);
        repeat (2) @(posedge clk_sys_in);
        complete_run;
    end
endmodule
`default_nettype wire
